// ==== core/pcrel_pkg.sv ====
// Package of constants and types for the program-counter-relative operand address unit.
package pcrel_pkg;
   localparam int ADDR_W = 32;
   localparam logic [3:0] MODE_REL_BYTE = 4'ha;
   localparam logic [3:0] MODE_DEF_BYTE = 4'hb;
   localparam logic [3:0] MODE_REL_WORD = 4'hc;
   localparam logic [3:0] MODE_DEF_WORD = 4'hd;
   localparam logic [3:0] MODE_REL_LONG = 4'he;
   localparam logic [3:0] MODE_DEF_LONG = 4'hf;
   localparam logic [3:0] MODE_REGISTER = 4'h5;
   localparam logic [3:0] MODE_INDEX = 4'h4;
   localparam logic [3:0] REG_PC = 4'hf;
   localparam logic [2:0] LEN_BYTE = 3'h1;
   localparam logic [2:0] LEN_WORD = 3'h2;
   localparam logic [2:0] LEN_LONG = 3'h4;
   localparam int FIFO_DEPTH = 4;
   // Data types.
   localparam logic [2:0] DT_BYTE = 3'h0;
   localparam logic [2:0] DT_WORD = 3'h1;
   localparam logic [2:0] DT_LONG = 3'h2;
   localparam logic [2:0] DT_FLOAT = 3'h3;
   localparam logic [2:0] DT_DOUBLE = 3'h4;
   // Operation classes.
   localparam logic [3:0] OP_MOVE = 4'h0;
   localparam logic [3:0] OP_CLEAR = 4'h1;
   localparam logic [3:0] OP_MOVE_NEGATED = 4'h2;
   localparam logic [3:0] OP_COMPARE = 4'h3;
   localparam logic [3:0] OP_TEST_ZERO = 4'h4;
   localparam logic [3:0] OP_MOVE_INVERTED = 4'h5;
   localparam logic [3:0] OP_MASK_TEST = 4'h6;
   localparam logic [3:0] OP_ADD = 4'h7;
   // Branch kinds.
   localparam logic [2:0] BR_FLAG_ONE = 3'h0;
   localparam logic [2:0] BR_FLAG_ONE_THEN_ZERO = 3'h1;
   localparam logic [2:0] BR_LSB_ONE = 3'h2;
   localparam logic [2:0] BR_BELOW_UNSIGNED = 3'h3;
   localparam logic [2:0] BR_ABOVE_UNSIGNED = 3'h4;
   typedef enum logic [2:0] {
      PCREL_IDLE = 3'b000,
      PCREL_DISP = 3'b001,
      PCREL_ADDR = 3'b011,
      PCREL_MEMRD = 3'b010,
      PCREL_DONE = 3'b110
   } pcrel_state_t;
endpackage

// ==== core/pcrel_disp_shift.sv ====
// Little-endian displacement byte collector with sign extension.
`timescale 1ns/1ps
module pcrel_disp_shift (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Control.
   input wire logic clear_i,
   input wire logic load_i,
   input wire logic [1:0] index_i,
   input wire logic [7:0] byte_i,
   input wire logic [2:0] len_i,
   // Result.
   output logic [31:0] value_o
);
   logic [31:0] raw_r;
   logic [31:0] raw_nxt;

   always_comb begin
      raw_nxt = raw_r;
      if (clear_i) begin
         raw_nxt = 32'h0000_0000;
      end else if (load_i) begin
         raw_nxt[index_i*8 +: 8] = byte_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         raw_r <= 32'h0000_0000;
      end else begin
         raw_r <= raw_nxt;
      end
   end

   // Sign extension by length keeps byte and word forms negative where needed.
   always_comb begin
      if (len_i == pcrel_pkg::LEN_BYTE) begin
         value_o = {{24{raw_r[7]}}, raw_r[7:0]};
      end else if (len_i == pcrel_pkg::LEN_WORD) begin
         value_o = {{16{raw_r[15]}}, raw_r[15:0]};
      end else begin
         value_o = raw_r;
      end
   end
endmodule

// ==== core/pcrel_addr_unit.sv ====
// Program-counter-relative operand address and branch target unit.
//
// Notes on behaviour
// - Modes A, C, E with PC are relative.
// - Relative address is displacement plus PC.
// - Modes B, D, F with PC are deferred.
// - Deferred mode fetches longword address from memory.
// - PC used is past the displacement.
// - Branch displacement sign-extended to 32 bits.
// - Branch PC is byte after displacement.
// - Flag-one branch; clearing variant clears bit.
// - LSB branch taken when bit 0 set.
// - Unsigned branches use unsigned compare result.
// - Move, clear, negate, compare, test: all types.
// - Inverted move and mask test: integers only.
// - Add decoded for all five types.
// - PC with register or index unpredictable.
`timescale 1ns/1ps
module pcrel_addr_unit (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Specifier request.
   input wire logic spec_valid_i,
   input wire logic [7:0] spec_byte_i,
   input wire logic [31:0] spec_pc_i,
   // Instruction byte stream.
   input wire logic stream_valid_i,
   input wire logic [7:0] stream_byte_i,
   output logic stream_take_o,
   // Memory read port.
   output logic mem_req_o,
   output logic [31:0] mem_addr_o,
   input wire logic mem_ack_i,
   input wire logic [31:0] mem_data_i,
   // Operand address result.
   output logic addr_valid_o,
   output logic [31:0] addr_o,
   output logic [31:0] next_pc_o,
   output logic spec_busy_o,
   output logic spec_bad_o,
   // Branch evaluation.
   input wire logic br_valid_i,
   input wire logic [2:0] br_kind_i,
   input wire logic br_word_i,
   input wire logic [15:0] br_disp_i,
   input wire logic [31:0] br_pc_i,
   input wire logic [31:0] br_base_i,
   input wire logic [4:0] br_pos_i,
   input wire logic br_carry_i,
   input wire logic br_zero_i,
   output logic br_done_o,
   output logic br_taken_o,
   output logic [31:0] br_target_o,
   output logic br_clear_bit_o,
   output logic [31:0] br_new_base_o,
   // Data type decode.
   input wire logic [3:0] op_class_i,
   input wire logic [2:0] op_type_i,
   output logic op_legal_o
);
   ////////////////////////////////////////////////////////////////////////////
   pcrel_pkg::pcrel_state_t state_r;
   pcrel_pkg::pcrel_state_t state_nxt;
   logic deferred_r;
   logic deferred_nxt;
   logic [2:0] len_r;
   logic [2:0] len_nxt;
   logic [2:0] cnt_r;
   logic [2:0] cnt_nxt;
   logic [31:0] pc_r;
   logic [31:0] pc_nxt;
   logic mem_req_r;
   logic mem_req_nxt;
   logic [31:0] mem_addr_r;
   logic [31:0] mem_addr_nxt;
   logic addr_valid_r;
   logic addr_valid_nxt;
   logic [31:0] addr_r;
   logic [31:0] addr_nxt;
   logic [31:0] next_pc_r;
   logic [31:0] next_pc_nxt;
   logic bad_r;
   logic bad_nxt;
   logic busy_r;
   logic busy_nxt;
   logic take;
   logic disp_clear;
   logic [31:0] disp_val;
   logic [3:0] spec_mode;
   logic [3:0] spec_reg;

   // Displacement length for a PC-relative mode, zero for any other mode.
   function automatic logic [2:0] disp_len(input logic [3:0] mode);
      logic [2:0] len;
      len = 3'h0;
      if (mode == pcrel_pkg::MODE_REL_BYTE || mode == pcrel_pkg::MODE_DEF_BYTE) begin
         len = pcrel_pkg::LEN_BYTE;
      end else if (mode == pcrel_pkg::MODE_REL_WORD || mode == pcrel_pkg::MODE_DEF_WORD) begin
         len = pcrel_pkg::LEN_WORD;
      end else if (mode == pcrel_pkg::MODE_REL_LONG || mode == pcrel_pkg::MODE_DEF_LONG) begin
         len = pcrel_pkg::LEN_LONG;
      end
      return len;
   endfunction

   assign spec_mode = spec_byte_i[7:4];
   assign spec_reg = spec_byte_i[3:0];
   assign take = (state_r == pcrel_pkg::PCREL_DISP) && stream_valid_i;
   assign disp_clear = (state_r == pcrel_pkg::PCREL_IDLE);

   pcrel_disp_shift u_disp (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .clear_i(disp_clear),
      .load_i(take),
      .index_i(cnt_r[1:0]),
      .byte_i(stream_byte_i),
      .len_i(len_r),
      .value_o(disp_val)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_nxt = state_r;
      deferred_nxt = deferred_r;
      len_nxt = len_r;
      cnt_nxt = cnt_r;
      pc_nxt = pc_r;
      mem_req_nxt = mem_req_r;
      mem_addr_nxt = mem_addr_r;
      addr_valid_nxt = 1'b0;
      addr_nxt = addr_r;
      next_pc_nxt = next_pc_r;
      bad_nxt = 1'b0;
      case (state_r)
         pcrel_pkg::PCREL_IDLE: begin
            if (spec_valid_i) begin
               if (spec_reg == pcrel_pkg::REG_PC && disp_len(spec_mode) != 3'h0) begin
                  state_nxt = pcrel_pkg::PCREL_DISP;
                  len_nxt = disp_len(spec_mode);
                  deferred_nxt = spec_mode[0];
                  cnt_nxt = 3'h0;
                  pc_nxt = spec_pc_i;
               end else begin
                  // PC with register or index mode, or a mode this unit does not own, is refused.
                  bad_nxt = 1'b1;
               end
            end
         end
         pcrel_pkg::PCREL_DISP: begin
            if (stream_valid_i) begin
               cnt_nxt = cnt_r + 3'h1;
               pc_nxt = pc_r + 32'h0000_0001;
               if (cnt_r + 3'h1 == len_r) begin
                  state_nxt = pcrel_pkg::PCREL_ADDR;
               end
            end
         end
         pcrel_pkg::PCREL_ADDR: begin
            next_pc_nxt = pc_r;
            if (deferred_r) begin
               mem_req_nxt = 1'b1;
               mem_addr_nxt = pc_r + disp_val;
               state_nxt = pcrel_pkg::PCREL_MEMRD;
            end else begin
               addr_nxt = pc_r + disp_val;
               addr_valid_nxt = 1'b1;
               state_nxt = pcrel_pkg::PCREL_DONE;
            end
         end
         pcrel_pkg::PCREL_MEMRD: begin
            if (mem_ack_i) begin
               mem_req_nxt = 1'b0;
               addr_nxt = mem_data_i;
               addr_valid_nxt = 1'b1;
               state_nxt = pcrel_pkg::PCREL_DONE;
            end
         end
         default: begin
            state_nxt = pcrel_pkg::PCREL_IDLE;
         end
      endcase
      // Busy is registered from the next state, so it matches the state register edge for edge.
      busy_nxt = (state_nxt != pcrel_pkg::PCREL_IDLE);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= pcrel_pkg::PCREL_IDLE;
         deferred_r <= 1'b0;
         len_r <= 3'h0;
         cnt_r <= 3'h0;
         pc_r <= 32'h0000_0000;
         mem_req_r <= 1'b0;
         mem_addr_r <= 32'h0000_0000;
         addr_valid_r <= 1'b0;
         addr_r <= 32'h0000_0000;
         next_pc_r <= 32'h0000_0000;
         bad_r <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         deferred_r <= deferred_nxt;
         len_r <= len_nxt;
         cnt_r <= cnt_nxt;
         pc_r <= pc_nxt;
         mem_req_r <= mem_req_nxt;
         mem_addr_r <= mem_addr_nxt;
         addr_valid_r <= addr_valid_nxt;
         addr_r <= addr_nxt;
         next_pc_r <= next_pc_nxt;
         bad_r <= bad_nxt;
         busy_r <= busy_nxt;
      end
   end

   // The stream take is combinational so a byte is consumed in the cycle it is offered.
   assign stream_take_o = take;
   assign mem_req_o = mem_req_r;
   assign mem_addr_o = mem_addr_r;
   assign addr_valid_o = addr_valid_r;
   assign addr_o = addr_r;
   assign next_pc_o = next_pc_r;
   assign spec_busy_o = busy_r;
   assign spec_bad_o = bad_r;

   ////////////////////////////////////////////////////////////////////////////
   logic br_done_r;
   logic br_done_nxt;
   logic br_taken_r;
   logic br_taken_nxt;
   logic [31:0] br_target_r;
   logic [31:0] br_target_nxt;
   logic br_clear_r;
   logic br_clear_nxt;
   logic [31:0] br_base_r;
   logic [31:0] br_base_nxt;
   logic [31:0] br_ext;
   logic [31:0] bit_mask;

   always_comb begin
      br_done_nxt = br_valid_i;
      br_taken_nxt = 1'b0;
      br_target_nxt = br_target_r;
      br_clear_nxt = 1'b0;
      br_base_nxt = br_base_r;
      bit_mask = 32'h0000_0001 << br_pos_i;
      if (br_word_i) begin
         br_ext = {{16{br_disp_i[15]}}, br_disp_i};
      end else begin
         br_ext = {{24{br_disp_i[7]}}, br_disp_i[7:0]};
      end
      if (br_valid_i) begin
         br_target_nxt = br_pc_i + br_ext;
         br_base_nxt = br_base_i;
         case (br_kind_i)
            pcrel_pkg::BR_FLAG_ONE: begin
               br_taken_nxt = (br_base_i & bit_mask) != 32'h0000_0000;
            end
            pcrel_pkg::BR_FLAG_ONE_THEN_ZERO: begin
               br_taken_nxt = (br_base_i & bit_mask) != 32'h0000_0000;
               br_clear_nxt = 1'b1;
               br_base_nxt = br_base_i & ~bit_mask;
            end
            pcrel_pkg::BR_LSB_ONE: begin
               br_taken_nxt = br_base_i[0];
            end
            pcrel_pkg::BR_BELOW_UNSIGNED: begin
               br_taken_nxt = br_carry_i;
            end
            pcrel_pkg::BR_ABOVE_UNSIGNED: begin
               br_taken_nxt = !br_carry_i && !br_zero_i;
            end
            default: begin
               br_taken_nxt = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         br_done_r <= 1'b0;
         br_taken_r <= 1'b0;
         br_target_r <= 32'h0000_0000;
         br_clear_r <= 1'b0;
         br_base_r <= 32'h0000_0000;
      end else begin
         br_done_r <= br_done_nxt;
         br_taken_r <= br_taken_nxt;
         br_target_r <= br_target_nxt;
         br_clear_r <= br_clear_nxt;
         br_base_r <= br_base_nxt;
      end
   end

   assign br_done_o = br_done_r;
   assign br_taken_o = br_taken_r;
   assign br_target_o = br_target_r;
   assign br_clear_bit_o = br_clear_r;
   assign br_new_base_o = br_base_r;

   ////////////////////////////////////////////////////////////////////////////
   logic legal_r;
   logic legal_nxt;

   always_comb begin
      legal_nxt = 1'b0;
      if (op_class_i == pcrel_pkg::OP_MOVE_INVERTED || op_class_i == pcrel_pkg::OP_MASK_TEST) begin
         legal_nxt = (op_type_i <= pcrel_pkg::DT_LONG);
      end else if (op_class_i <= pcrel_pkg::OP_TEST_ZERO) begin
         legal_nxt = (op_type_i <= pcrel_pkg::DT_DOUBLE);
      end else if (op_class_i == pcrel_pkg::OP_ADD) begin
         legal_nxt = (op_type_i <= pcrel_pkg::DT_DOUBLE);
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         legal_r <= 1'b0;
      end else begin
         legal_r <= legal_nxt;
      end
   end

   assign op_legal_o = legal_r;
endmodule

// ==== bench/pcrel_props.sv ====
// Concurrent checks on the relative operand address unit.
`timescale 1ns/1ps
module pcrel_props (
   // Clock, reset and specifier side.
   input wire logic clk_i, rst_n_i, spec_valid_i, spec_busy_o, spec_bad_o, addr_valid_o, stream_take_o,
   input wire logic [7:0] spec_byte_i, stream_byte_i,
   input wire logic [31:0] spec_pc_i, addr_o, next_pc_o,
   // Memory port.
   input wire logic mem_req_o, mem_ack_i,
   input wire logic [31:0] mem_addr_o, mem_data_i,
   // Branch and decode.
   input wire logic br_valid_i, br_word_i, br_carry_i, br_zero_i, br_done_o, br_taken_o, br_clear_bit_o,
   input wire logic op_legal_o,
   input wire logic [2:0] br_kind_i, op_type_i,
   input wire logic [3:0] op_class_i,
   input wire logic [4:0] br_pos_i,
   input wire logic [15:0] br_disp_i,
   input wire logic [31:0] br_pc_i, br_base_i, br_target_o, br_new_base_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   ////////////////////////////////////////////////////////////////////////////////
   // Helper state mirrors the specifier in flight, so results are judged against their cause.
   logic take, tk_exp, legal_exp;
   logic [3:0] mode_r;
   logic [1:0] k_r;
   logic [31:0] pc_r, disp_r, ln, ex, br_exp;
   assign take = spec_valid_i && !spec_busy_o;
   assign ln = (mode_r[2:1] == 2'b01) ? 32'h1 : (mode_r[2:1] == 2'b10) ? 32'h2 : 32'h4;
   assign ex = pc_r + ln + ((ln == 32'h1) ? {{24{disp_r[7]}}, disp_r[7:0]} :
      (ln == 32'h2) ? {{16{disp_r[15]}}, disp_r[15:0]} : disp_r);
   assign br_exp = br_pc_i + (br_word_i ? {{16{br_disp_i[15]}}, br_disp_i} : {{24{br_disp_i[7]}}, br_disp_i[7:0]});
   assign tk_exp = (br_kind_i <= 3'h1) ? br_base_i[br_pos_i] : (br_kind_i == 3'h2) ? br_base_i[0] :
      (br_kind_i == 3'h3) ? br_carry_i : !br_carry_i && !br_zero_i;
   assign legal_exp = (op_type_i <= 3'h4) && (op_class_i <= 4'h4 || op_class_i == 4'h7 ||
      ((op_class_i == 4'h5 || op_class_i == 4'h6) && op_type_i <= 3'h2));
   always_ff @(posedge clk_i) begin
      if (take) begin
         mode_r <= spec_byte_i[7:4];
         pc_r <= spec_pc_i;
         disp_r <= 32'h0;
         k_r <= 2'h0;
      end else if (stream_take_o) begin
         disp_r[k_r*8 +: 8] <= stream_byte_i;
         k_r <= k_r + 2'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   spec_rel_a: assert property (take && spec_byte_i[3:0] == 4'hf && spec_byte_i[7:4] >= 4'ha
      |=> spec_busy_o) else $error("relative specifier refused");
   bad_spec_a: assert property (take && (spec_byte_i[3:0] != 4'hf || spec_byte_i[7:4] < 4'ha)
      |=> spec_bad_o) else $error("bad specifier not flagged");
   rel_addr_a: assert property (addr_valid_o && !mode_r[0] |-> addr_o == ex)
      else $error("relative address wrong");
   next_pc_a: assert property (addr_valid_o |-> next_pc_o == pc_r + ln)
      else $error("next pc wrong");
   rel_time_a: assert property (take && spec_byte_i == 8'haf ##1 stream_take_o |=> ##1 addr_valid_o)
      else $error("byte relative result late");
   def_req_a: assert property ($rose(mem_req_o) |-> mode_r[0] && mem_addr_o == ex)
      else $error("deferred read address wrong");
   req_hold_a: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o))
      else $error("read request dropped");
   def_addr_a: assert property (mem_req_o && mem_ack_i |=> addr_valid_o && addr_o == $past(mem_data_i))
      else $error("deferred address wrong");
   br_target_a: assert property (br_valid_i |=> br_done_o && br_target_o == $past(br_exp))
      else $error("branch target wrong");
   br_taken_a: assert property (br_valid_i && br_kind_i <= 3'h4 |=> br_taken_o == $past(tk_exp))
      else $error("branch decision wrong");
   br_clear_a: assert property (br_valid_i && br_kind_i == 3'h1 && tk_exp |=> br_clear_bit_o &&
      br_new_base_o == ($past(br_base_i) & ~(32'h1 << $past(br_pos_i)))) else $error("bit not cleared");
   op_legal_a: assert property (1'b1 |=> op_legal_o == $past(legal_exp))
      else $error("type decode wrong");
   cover property (take && spec_byte_i[4]);
   cover property (addr_valid_o && !mode_r[0]);
   cover property (br_valid_i ##1 br_taken_o);
endmodule
bind pcrel_addr_unit pcrel_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .spec_valid_i(spec_valid_i),
   .spec_busy_o(spec_busy_o), .spec_bad_o(spec_bad_o), .addr_valid_o(addr_valid_o), .stream_take_o(stream_take_o),
   .spec_byte_i(spec_byte_i), .stream_byte_i(stream_byte_i), .spec_pc_i(spec_pc_i), .addr_o(addr_o),
   .next_pc_o(next_pc_o), .mem_req_o(mem_req_o), .mem_ack_i(mem_ack_i), .mem_addr_o(mem_addr_o),
   .mem_data_i(mem_data_i), .br_valid_i(br_valid_i), .br_word_i(br_word_i), .br_carry_i(br_carry_i),
   .br_zero_i(br_zero_i), .br_done_o(br_done_o), .br_taken_o(br_taken_o), .br_clear_bit_o(br_clear_bit_o),
   .op_legal_o(op_legal_o), .br_kind_i(br_kind_i), .op_type_i(op_type_i), .op_class_i(op_class_i),
   .br_pos_i(br_pos_i), .br_disp_i(br_disp_i), .br_pc_i(br_pc_i), .br_base_i(br_base_i),
   .br_target_o(br_target_o), .br_new_base_o(br_new_base_o));

// ==== bench/pcrel_mem_model.sv ====
// Behavioural instruction stream and memory that face the address unit.
`timescale 1ns/1ps
module pcrel_mem_model (
   // Clock, reset and bench controls.
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic slow_i,
   input wire logic start_i,
   input wire logic [31:0] disp_i,
   // Instruction stream.
   input wire logic stream_take_i,
   output logic stream_valid_o,
   output logic [7:0] stream_byte_o,
   // Memory read port.
   input wire logic mem_req_i,
   input wire logic [31:0] mem_addr_i,
   output logic mem_ack_o,
   output logic [31:0] mem_data_o
);
   ////////////////////////////////////////////////////////////////////////////////
   // A slow partner offers a byte only every other cycle and answers reads three cycles late.
   logic gap_r;
   logic [1:0] idx_r, wait_r;
   assign stream_valid_o = !slow_i || gap_r;
   // Idle byte lanes show the inverse, so a stale byte can never pass for a fresh one.
   assign stream_byte_o = stream_valid_o ? disp_i[idx_r*8 +: 8] : ~disp_i[idx_r*8 +: 8];
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         gap_r <= 1'b0;
         idx_r <= 2'h0;
         wait_r <= 2'h0;
         mem_ack_o <= 1'b0;
         mem_data_o <= 32'h0;
      end else begin
         gap_r <= !gap_r;
         mem_ack_o <= 1'b0;
         mem_data_o <= ~mem_data_o;
         if (start_i)
            idx_r <= 2'h0;
         else if (stream_take_i)
            idx_r <= idx_r + 2'h1;
         if (mem_req_i && !mem_ack_o) begin
            if (wait_r == {slow_i, slow_i}) begin
               mem_ack_o <= 1'b1;
               mem_data_o <= mem_addr_i ^ 32'h5a5a0f0f;
               wait_r <= 2'h0;
            end else begin
               wait_r <= wait_r + 2'h1;
            end
         end
      end
   end
endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the relative operand address unit.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("Error %s expected %h seen %h", n, e, g); end end
module tb;
   logic clk_i = 1'b0, rst_n_i = 1'b0, spec_valid_i = 1'b0, br_valid_i = 1'b0, br_word_i = 1'b0;
   logic br_carry_i = 1'b0, br_zero_i = 1'b0, slow = 1'b0;
   logic [7:0] spec_byte_i = 8'h00;
   logic [2:0] br_kind_i = 3'h0, op_type_i = 3'h0;
   logic [3:0] op_class_i = 4'h0;
   logic [4:0] br_pos_i = 5'h00;
   logic [15:0] br_disp_i = 16'h0000;
   logic [31:0] spec_pc_i = 32'h0, br_pc_i = 32'h0, br_base_i = 32'h0, disp = 32'h0;
   logic stream_valid_i, stream_take_o, mem_req_o, mem_ack_i, addr_valid_o, spec_busy_o, spec_bad_o;
   logic br_done_o, br_taken_o, br_clear_bit_o, op_legal_o;
   logic [7:0] stream_byte_i;
   logic [31:0] mem_addr_o, mem_data_i, addr_o, next_pc_o, br_target_o, br_new_base_o;
   int n_errors = 0;
   int total_checks = 0;
   always #20 clk_i = ~clk_i;
   pcrel_addr_unit u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .spec_valid_i(spec_valid_i),
      .spec_byte_i(spec_byte_i), .spec_pc_i(spec_pc_i), .stream_valid_i(stream_valid_i),
      .stream_byte_i(stream_byte_i), .stream_take_o(stream_take_o), .mem_req_o(mem_req_o),
      .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .mem_data_i(mem_data_i), .addr_valid_o(addr_valid_o),
      .addr_o(addr_o), .next_pc_o(next_pc_o), .spec_busy_o(spec_busy_o), .spec_bad_o(spec_bad_o),
      .br_valid_i(br_valid_i), .br_kind_i(br_kind_i), .br_word_i(br_word_i), .br_disp_i(br_disp_i),
      .br_pc_i(br_pc_i), .br_base_i(br_base_i), .br_pos_i(br_pos_i), .br_carry_i(br_carry_i),
      .br_zero_i(br_zero_i), .br_done_o(br_done_o), .br_taken_o(br_taken_o), .br_target_o(br_target_o),
      .br_clear_bit_o(br_clear_bit_o), .br_new_base_o(br_new_base_o), .op_class_i(op_class_i),
      .op_type_i(op_type_i), .op_legal_o(op_legal_o));
   pcrel_mem_model u_mem (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow), .start_i(spec_valid_i),
      .disp_i(disp), .stream_take_i(stream_take_o), .stream_valid_o(stream_valid_i),
      .stream_byte_o(stream_byte_i), .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o),
      .mem_ack_o(mem_ack_i), .mem_data_o(mem_data_i));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Offers one specifier and judges the address, or the refusal, that comes back.
   task automatic spec(input logic [7:0] sb, input logic [31:0] pc, input logic [31:0] d, input logic bad);
      logic [31:0] ln;
      logic [31:0] ex;
      int i;
      ln = (sb[6:5] == 2'b01) ? 32'h1 : (sb[6:5] == 2'b10) ? 32'h2 : 32'h4;
      ex = pc + ln + ((ln == 32'h1) ? {{24{d[7]}}, d[7:0]} : (ln == 32'h2) ? {{16{d[15]}}, d[15:0]} : d);
      if (sb[4])
         ex = ex ^ 32'h5a5a0f0f;
      disp = d;
      spec_byte_i = sb;
      spec_pc_i = pc;
      spec_valid_i = 1'b1;
      @(negedge clk_i);
      spec_valid_i = 1'b0;
      `CHK("spec_busy", !bad, spec_busy_o)
      i = 0;
      while (addr_valid_o !== 1'b1 && spec_bad_o !== 1'b1 && i < 40) begin
         @(negedge clk_i);
         i++;
      end
      `CHK("spec_bad", bad, spec_bad_o)
      if (!bad) begin
         `CHK("addr", ex, addr_o)
         `CHK("next_pc", pc + ln, next_pc_o)
      end
      @(negedge clk_i);
   endtask
   // Back-to-back branches: valid stays high between calls and drops after the last.
   task automatic br(input logic [2:0] k, input logic w, input logic [15:0] d, input logic [31:0] b,
         input logic [4:0] p, input logic c, input logic z, input logic tk);
      logic [31:0] ex;
      ex = 32'h8000 + (w ? {{16{d[15]}}, d} : {{24{d[7]}}, d[7:0]});
      br_kind_i = k;
      br_word_i = w;
      br_disp_i = d;
      br_pc_i = 32'h8000;
      br_base_i = b;
      br_pos_i = p;
      br_carry_i = c;
      br_zero_i = z;
      br_valid_i = 1'b1;
      @(negedge clk_i);
      `CHK("br_done", 1'b1, br_done_o)
      `CHK("br_taken", tk, br_taken_o)
      `CHK("br_target", ex, br_target_o)
      `CHK("br_clear_bit", k == 3'h1, br_clear_bit_o)
      if (k == 3'h1 && tk) begin
         `CHK("br_new_base", b & ~(32'h1 << p), br_new_base_o)
      end
   endtask
   task automatic t_decode;
      logic ok;
      for (int c = 0; c < 9; c++) begin
         for (int t = 0; t < 6; t++) begin
            op_class_i = 4'(c);
            op_type_i = 3'(t);
            ok = (t <= 4) && (c <= 4 || c == 7 || ((c == 5 || c == 6) && t <= 2));
            @(negedge clk_i);
            `CHK("op_legal", ok, op_legal_o)
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #40000;
      n_errors++;
      finish_test();
   end
   initial begin
      repeat (6) @(posedge clk_i);
      @(negedge clk_i);
      rst_n_i = 1'b1;
      spec(8'haf, 32'h1000, 32'h00000080, 1'b0);
      spec(8'hcf, 32'h2000, 32'h00008001, 1'b0);
      spec(8'hef, 32'h3000, 32'hfffffff0, 1'b0);
      spec(8'hbf, 32'h2002, 32'h0000004d, 1'b0);
      slow = 1'b1;
      spec(8'hdf, 32'h4000, 32'h00007fff, 1'b0);
      spec(8'hff, 32'h5000, 32'h12345678, 1'b0);
      spec(8'haf, 32'h6000, 32'h000000ff, 1'b0);
      spec(8'h5f, 32'h0, 32'h0, 1'b1);
      spec(8'h4f, 32'h0, 32'h0, 1'b1);
      spec(8'hae, 32'h0, 32'h0, 1'b1);
      spec(8'h8f, 32'h0, 32'h0, 1'b1);
      br(3'h0, 1'b0, 16'h12f0, 32'h4, 5'h2, 1'b0, 1'b0, 1'b1);
      br(3'h0, 1'b1, 16'h8000, 32'hfffffffb, 5'h2, 1'b0, 1'b0, 1'b0);
      br(3'h1, 1'b1, 16'h0100, 32'h80000001, 5'h1f, 1'b0, 1'b0, 1'b1);
      br(3'h2, 1'b0, 16'h0010, 32'h1, 5'h0, 1'b0, 1'b0, 1'b1);
      br(3'h2, 1'b0, 16'h0010, 32'h2, 5'h0, 1'b0, 1'b0, 1'b0);
      br(3'h3, 1'b0, 16'h0020, 32'h0, 5'h0, 1'b1, 1'b0, 1'b1);
      br(3'h3, 1'b0, 16'h0020, 32'h0, 5'h0, 1'b0, 1'b1, 1'b0);
      br(3'h4, 1'b0, 16'h0030, 32'h0, 5'h0, 1'b0, 1'b0, 1'b1);
      br(3'h4, 1'b0, 16'h0030, 32'h0, 5'h0, 1'b0, 1'b1, 1'b0);
      br(3'h4, 1'b0, 16'h0030, 32'h0, 5'h0, 1'b1, 1'b0, 1'b0);
      br_valid_i = 1'b0;
      t_decode();
      finish_test();
   end
endmodule
